// file: rtl/spi_nv_cmd.sv
// Purpose: Command logic of an 8K x 8 serial nonvolatile memory (SPI slave)
// Assumes: clk well above the link clock; link pins are asynchronous
// Notes: The array is a register array; nonvolatile bits are plain flops
//
// Behaviour
// - First eight bits after select form command
// - Partial command at deselect does nothing
// - Code 06 sets the write enable latch
// - Code 04 clears the write enable latch
// - Latch clear blocks status and array writes
// - Code 05 shifts status out on falling edges
// - Continued clocks repeat the status byte
// - Code 01 loads following eight bits into status
// - Status write ignores latch bit and bit 0
// - Code 03 plus address streams array data out
// - Read increments address, wraps at top
// - Code 02, address, bytes decode as write
// - Each full byte stored at once
// - Write increments address, wraps at top
// - Block protect bits pick protected range
// - Latch gates all writes; protect enable and pin gate status writes
// - Hold low suspends command without abort
// - Hold judged against clock level
// - While held ignore clock, float output
// - Deselect in hold aborts, latch kept unless code 01 or 02 was taken
// - Latch cleared at reset, 04, write end
// - Status layout enable, spare, protect, latch, zero
// - Sample on rising, drive on falling edge
`timescale 1ns/1ps
`default_nettype none
`include "spi_nv_defines.svh"

module spi_nv_cmd #(
  parameter int ADDR_W = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link pins
  input wire logic sel_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  // Serial output pin with enable
  output logic so,
  output logic so_oe,
  // Status view
  output logic [7:0] status
);
  import spi_nv_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  // Elaboration check: the protect map needs thirteen address bits
  if (ADDR_W != 13) begin : g_bad_width
    $error("ADDR_W must be 13");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  link_in_t meta; // First stage, read only by the second
  link_in_t pins; // Safe sampled pins
  logic sck_prev; // Previous sampled clock level

  // Two flops on every pin before use
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '{sel_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
      pins <= '{sel_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};
    end else begin
      meta <= '{sel_n: sel_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};
      pins <= meta;
    end
  end

  // ****************************************
  // Edge and hold detection
  // ****************************************
  logic held; // Hold active
  logic held_sck; // Clock level at hold entry
  logic rise; // Usable rising edge
  logic fall; // Usable falling edge

  // Clock level history, frozen while held so no edge leaks out
  always_ff @(posedge clk) begin
    if (srst) begin
      sck_prev <= 1'b0;
    end else if (!held) begin
      sck_prev <= pins.sck;
    end
  end

  // Hold entry and exit at the clock level seen at entry
  always_ff @(posedge clk) begin
    if (srst || pins.sel_n) begin
      held <= 1'b0; // Deselect aborts the held command
      held_sck <= 1'b0;
    end else if (!held && !pins.hold_n) begin
      held <= 1'b1;
      held_sck <= pins.sck;
    end else if (held && pins.hold_n && pins.sck == held_sck) begin
      held <= 1'b0;
    end
  end

  // Edges count only while selected and not held
  assign rise = !pins.sel_n && !held && pins.sck && !sck_prev;
  assign fall = !pins.sel_n && !held && !pins.sck && sck_prev;

  // ****************************************
  // Protection decode
  // ****************************************
  logic latch; // Write enable latch
  logic [7:0] nv_stat; // Nonvolatile status bits
  logic [ADDR_W-1:0] addr; // Current array address

  // True when the address lies in the block-protected range
  function automatic logic in_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
    case (bp)
      2'b00: in_protected = 1'b0;
      2'b01: in_protected = (a >= `BP_QUARTER_BASE);
      2'b10: in_protected = (a >= `BP_HALF_BASE);
      default: in_protected = 1'b1;
    endcase
  endfunction : in_protected

  logic array_ok; // Array write allowed at addr
  logic stat_ok; // Status write allowed
  assign array_ok = latch && !in_protected({nv_stat[`ST_BP_HI], nv_stat[`ST_BP_LO]}, addr);
  assign stat_ok = latch && !(nv_stat[`ST_PROTECT_EN] && !pins.wp_n);

  // ****************************************
  // Shift engine
  // ****************************************
  phase_t phase; // Current phase
  logic [2:0] bitcnt; // Bits taken in current byte
  logic [4:0] addr_cnt; // Address bits taken
  logic [7:0] shin; // Input shift register
  logic [7:0] shout; // Output shift register
  logic [7:0] mem [DEPTH]; // Array storage
  logic wr_cmd; // Status or array write recognised
  logic [7:0] next_byte; // Byte completed by this rising edge
  logic byte_done; // Byte completes on this rising edge

  assign next_byte = {shin[6:0], pins.si};
  assign byte_done = rise && bitcnt == 3'd7;

  // Phase, counters and address; deselect clears the frame
  always_ff @(posedge clk) begin
    if (srst || pins.sel_n) begin
      phase <= PH_CMD;
      bitcnt <= 3'd0;
      addr_cnt <= 5'd0;
      shin <= 8'h00;
      wr_cmd <= 1'b0;
    end else if (rise) begin
      shin <= next_byte;
      bitcnt <= bitcnt + 3'd1;
      case (phase)
        PH_CMD: begin
          if (byte_done) begin
            case (next_byte)
              `CMD_STATUS_READ: phase <= PH_STREAD;
              `CMD_STATUS_WRITE: begin
                phase <= PH_STWRITE;
                wr_cmd <= 1'b1;
              end
              `CMD_ARRAY_READ: phase <= PH_ADDR;
              `CMD_ARRAY_WRITE: begin
                phase <= PH_ADDR;
                wr_cmd <= 1'b1;
              end
              default: phase <= PH_IDLE; // Latch codes 06, 04 and undefined codes
            endcase
          end
        end
        PH_ADDR: begin
          addr_cnt <= addr_cnt + 5'd1;
          // Top three address bits fall off the thirteen-bit register
          addr <= {addr[ADDR_W-2:0], pins.si};
          if (addr_cnt == 5'd15) begin
            phase <= wr_cmd ? PH_WDATA : PH_RDATA;
          end
        end
        PH_WDATA, PH_RDATA: begin
          if (byte_done) begin
            addr <= addr + 1'b1; // Wraps from top to zero
          end
        end
        PH_STWRITE: begin
          if (byte_done) begin
            phase <= PH_IDLE; // Extra bits are ignored
          end
        end
        default: ;
      endcase
    end
  end

  // Array store as soon as a byte is complete
  always_ff @(posedge clk) begin
    if (!srst && !pins.sel_n && byte_done && phase == PH_WDATA && array_ok) begin
      mem[addr] <= next_byte;
    end
  end

  // Write enable latch
  always_ff @(posedge clk) begin
    if (srst) begin
      latch <= 1'b0;
    end else if (pins.sel_n) begin
      if (wr_cmd) begin
        latch <= 1'b0;
      end
    end else if (byte_done && phase == PH_CMD) begin
      if (next_byte == `CMD_LATCH_SET) begin
        latch <= 1'b1;
      end else if (next_byte == `CMD_LATCH_CLEAR) begin
        latch <= 1'b0;
      end
    end
  end

  // Nonvolatile status bits; latch and bit 0 not writable
  always_ff @(posedge clk) begin
    if (srst) begin
      nv_stat <= `ST_RESET;
    end else if (!pins.sel_n && byte_done && phase == PH_STWRITE && stat_ok) begin
      nv_stat <= next_byte & `ST_NV_MASK;
    end
  end

  // ****************************************
  // Output path
  // ****************************************
  logic [7:0] stat_view; // Status as seen on the link
  assign stat_view = {nv_stat[7:2], latch, 1'b0};
  logic loading; // Next falling edge starts a fresh byte
  assign loading = bitcnt == 3'd0;

  // Shift out on falling edges; reload status or array data per byte
  always_ff @(posedge clk) begin
    if (srst || pins.sel_n) begin
      shout <= 8'h00;
      so <= 1'b0;
    end else if (fall && (phase == PH_STREAD || phase == PH_RDATA)) begin
      if (loading) begin
        shout <= {(phase == PH_STREAD ? stat_view[6:0] : mem[addr][6:0]), 1'b0};
        so <= phase == PH_STREAD ? stat_view[7] : mem[addr][7];
      end else begin
        shout <= {shout[6:0], 1'b0};
        so <= shout[7];
      end
    end
  end

  // Drive only in read phases, selected and not held
  always_ff @(posedge clk) begin
    if (srst) begin
      so_oe <= 1'b0;
    end else begin
      so_oe <= !pins.sel_n && !held && (phase == PH_STREAD || phase == PH_RDATA);
    end
  end

  // Status view port
  always_ff @(posedge clk) begin
    if (srst) begin
      status <= `ST_RESET;
    end else begin
      status <= stat_view;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_latch_set_cmd: assert property (@(posedge clk) disable iff (srst)
    (byte_done && phase == PH_CMD && next_byte == `CMD_LATCH_SET && !pins.sel_n) |=> latch)
    else $error("latch not set by set command");
  a_latch_clear_cmd: assert property (@(posedge clk) disable iff (srst)
    (byte_done && phase == PH_CMD && next_byte == `CMD_LATCH_CLEAR && !pins.sel_n) |=> !latch)
    else $error("latch not cleared by clear command");
  a_no_write_unlatched: assert property (@(posedge clk) disable iff (srst)
    !latch |=> $stable(nv_stat))
    else $error("status changed with latch clear");
  a_bit0_zero: assert property (@(posedge clk) disable iff (srst) !status[0])
    else $error("status bit 0 not zero");
  a_deselect_float: assert property (@(posedge clk) disable iff (srst)
    pins.sel_n |=> !so_oe)
    else $error("output driven while deselected");
  a_hold_float: assert property (@(posedge clk) disable iff (srst)
    held |=> !so_oe)
    else $error("output driven while held");
  a_write_end_clear: assert property (@(posedge clk) disable iff (srst)
    (pins.sel_n && wr_cmd) |=> !latch)
    else $error("latch kept after write command");
  a_addr_wrap: assert property (@(posedge clk) disable iff (srst)
    (byte_done && phase == PH_RDATA && !pins.sel_n) |=> addr == $past(addr) + 1'b1)
    else $error("read address not incremented");
  a_status_protect: assert property (@(posedge clk) disable iff (srst)
    (nv_stat[`ST_PROTECT_EN] && !pins.wp_n) |=> nv_stat == $past(nv_stat))
    else $error("status written while pin protected");

  // Status read code seen on the last command bit
  sequence s_status_cmd;
    byte_done && phase == PH_CMD && next_byte == `CMD_STATUS_READ && !pins.sel_n;
  endsequence : s_status_cmd
  a_status_read_entry: assert property (@(posedge clk) disable iff (srst)
    s_status_cmd |=> phase == PH_STREAD)
    else $error("status read phase not entered");

  // Full data byte at a writable address
  sequence s_byte_store;
    byte_done && phase == PH_WDATA && array_ok && !pins.sel_n;
  endsequence : s_byte_store
  a_array_store: assert property (@(posedge clk) disable iff (srst)
    s_byte_store |=> mem[$past(addr)] == $past(next_byte))
    else $error("array byte not stored");

endmodule : spi_nv_cmd

`default_nettype wire

// file: include/spi_nv_defines.svh
// Purpose: Constants of the serial nonvolatile memory command logic
// Assumes: Included by the design file and the bench
// Notes: Offsets, codes, positions, a mask and reset values only
`ifndef SPI_NV_DEFINES_SVH
`define SPI_NV_DEFINES_SVH

// ****************************************
// Command codes
// ****************************************
`define CMD_LATCH_SET 8'h06
`define CMD_LATCH_CLEAR 8'h04
`define CMD_STATUS_READ 8'h05
`define CMD_STATUS_WRITE 8'h01
`define CMD_ARRAY_READ 8'h03
`define CMD_ARRAY_WRITE 8'h02

// ****************************************
// Status bit positions, write mask and reset value
// ****************************************
`define ST_PROTECT_EN 7
`define ST_BP_HI 3
`define ST_BP_LO 2
`define ST_LATCH 1
`define ST_NV_MASK 8'hFC
`define ST_RESET 8'h00

// ****************************************
// Block protect starts
// ****************************************
`define BP_QUARTER_BASE 13'h1800
`define BP_HALF_BASE 13'h1000

`endif

// file: include/spi_nv_pkg.sv
// Purpose: Types of the serial nonvolatile memory command logic
// Assumes: None
// Notes: Constants live in the defines header
`default_nettype none

package spi_nv_pkg;

  // Phase of a selected transfer
  typedef enum logic [2:0] {
    PH_CMD,
    PH_ADDR,
    PH_RDATA,
    PH_WDATA,
    PH_STREAD,
    PH_STWRITE,
    PH_IDLE
  } phase_t;

  // Link pins after synchronising
  typedef struct packed {
    logic sel_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } link_in_t;

endpackage : spi_nv_pkg

`default_nettype wire

// file: bench/spi_master_model.sv
// Purpose: Master side of the link, mode 0, for the memory command logic
// Assumes: Half period of four clk cycles (320 ns link period)
// Notes: Pins change 1 ns after a clk edge; sck stands low between frames
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic sel_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so
);
  // Idle: deselected, clock low, not held
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end

  // Let n clk edges pass, then step clear of them
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Select, with setup before the first clock
  task automatic open_frame();
    sel_n = 1'b0;
    tick(4);
  endtask : open_frame

  // Deselect; released si shows the inverse of its last value
  task automatic close_frame();
    tick(4);
    sel_n = 1'b1;
    hold_n = 1'b1;
    si = ~si;
    tick(6);
  endtask : close_frame

  // Shift n bits MSB first; so taken late in the high phase
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      si = tx[7 - i];
      tick(4);
      sck = 1'b1;
      tick(3);
      rx = {rx[6:0], so};
      tick(1);
      sck = 1'b0;
    end
  endtask : shift

  // Hold with sck low; a clock pulse meanwhile must be ignored
  task automatic hold_on();
    hold_n = 1'b0;
    tick(4);
    sck = 1'b1;
    tick(4);
    sck = 1'b0;
    tick(4);
  endtask : hold_on

  // Release hold at the same sck level as at entry
  task automatic hold_off();
    hold_n = 1'b1;
    tick(4);
  endtask : hold_off
endmodule : spi_master_model

`default_nettype wire

// file: bench/serial_nv_memory_command_logic_test.sv
// Purpose: Self-checking bench of the memory command logic
// Assumes: Master model drives the link; bench drives wp_n
// Notes: Array starts unknown, so every read follows a write
`timescale 1ns/1ps
`default_nettype none
`include "spi_nv_defines.svh"

module serial_nv_memory_command_logic_test;
  localparam int WATCH_NS = 2_000_000; // Traffic needs about 0.54 ms; stays well under the cycle budget
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wp_n = 1'b1;
  wire logic sel_n, sck, si, hold_n, so, so_oe;
  wire logic [7:0] status;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] rx, r1;
  logic [7:0] rxq[$]; // Bytes seen on so in the last frame
  logic [15:0] addrs[4] = '{16'h0FFF, 16'h1000, 16'h17FF, 16'h1800};
  logic [7:0] mem[4]; // Expected contents at addrs
  logic [13:0] base; // First protected address

  always #20 clk = ~clk;

  spi_nv_cmd uut (.clk(clk), .srst(srst), .sel_n(sel_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .status(status));
  spi_master_model m (.clk(clk), .sel_n(sel_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so));

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One whole frame of bytes; answers kept in rxq; only defined codes are sent
  task automatic send(input logic [7:0] q[$]);
    rxq = {};
    m.open_frame();
    foreach (q[i]) begin
      m.shift(q[i], 8, rx);
      rxq.push_back(rx);
    end
    m.close_frame();
  endtask : send

  // Latch set, then status write
  task automatic set_status(input logic [7:0] v);
    send('{8'h06});
    send('{8'h01, v});
  endtask : set_status

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Watchdog against a hung link
  initial begin
    #(WATCH_NS);
    num_errors++;
    results();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    srst = 1'b0;
    m.tick(3);
    check(status, `ST_RESET);
    check({7'h0, so_oe}, 8'h00);
    send('{8'h06});
    check(status, 8'h02);
    send('{8'h04});
    check(status, 8'h00);
    done("latch");
    // Stream across the top with the ignored address bits set
    send('{8'h06});
    send('{8'h02, 8'hFF, 8'hFF, 8'h11, 8'h22, 8'h33});
    check(status, 8'h00);
    send('{8'h03, 8'h1F, 8'hFF, 8'h00, 8'h00, 8'h00});
    for (int i = 0; i < 3; i++) check(rxq[i + 3], 8'(8'h11 * (i + 1)));
    send('{8'h02, 8'h00, 8'h00, 8'h44});
    send('{8'h03, 8'h00, 8'h00, 8'h00});
    check(rxq[3], 8'h22);
    done("array");
    // Partial command, plain and under hold
    send('{8'h06});
    for (int h = 0; h < 2; h++) begin
      m.open_frame();
      m.shift(8'h04, 4, rx);
      if (h == 1) m.hold_on();
      m.close_frame();
      check(status, 8'h02);
    end
    send('{8'h04});
    done("partial");
    // Every block-protect code against both boundaries
    for (int bp = 0; bp < 4; bp++) begin
      base = (bp == 0) ? 14'h2000 : (bp == 1) ? 14'(`BP_QUARTER_BASE) :
        (bp == 2) ? 14'(`BP_HALF_BASE) : 14'h0000;
      set_status(8'(bp << 2));
      check(status, 8'(bp << 2));
      for (int k = 0; k < 4; k++) begin
        send('{8'h06});
        send('{8'h02, addrs[k][15:8], addrs[k][7:0], 8'(16 * bp + k + 1)});
        if (addrs[k] < base) mem[k] = 8'(16 * bp + k + 1);
        send('{8'h03, addrs[k][15:8], addrs[k][7:0], 8'h00});
        check(rxq[3], mem[k]);
      end
    end
    done("protect");
    set_status(8'h8F);
    check(status, 8'h8C);
    wp_n = 1'b0; // Settled before the next status write
    set_status(8'h00);
    check(status, 8'h8C);
    // Repeated status read, paused by hold in mid-byte
    m.open_frame();
    m.shift(8'h05, 8, rx);
    m.shift(8'h00, 8, rx);
    check(rx, 8'h8C);
    check({7'h0, so_oe}, 8'h01);
    m.shift(8'h00, 4, r1);
    m.hold_on();
    check({7'h0, so_oe}, 8'h00);
    m.hold_off();
    m.shift(8'h00, 4, rx);
    check({r1[3:0], rx[3:0]}, 8'h8C);
    m.close_frame();
    check({7'h0, so_oe}, 8'h00);
    wp_n = 1'b1;
    set_status(8'h00);
    check(status, 8'h00);
    done("hold");
    results();
  end
endmodule : serial_nv_memory_command_logic_test

`default_nettype wire
